// *** inc/drl_cfg.svh ***
// Constants of the diagnostic record block: offsets, fields, reset values.
// Assumes inclusion by bare name from design files and the testbench.
`ifndef DRL_CFG_SVH
`define DRL_CFG_SVH
// ****************************************************************
// Register byte offsets (aligned words)
// ****************************************************************
`define DRL_OFS_CTRL    8'h00
`define DRL_OFS_STATUS  8'h04
`define DRL_OFS_IRQ_ST  8'h08
`define DRL_OFS_IRQ_MSK 8'h0C
`define DRL_OFS_REC0    8'h10
`define DRL_OFS_REC1    8'h14
`define DRL_OFS_REC2    8'h18
`define DRL_OFS_REC3    8'h1C
// ****************************************************************
// Record field values
// ****************************************************************
`define DRL_CHTYPE_DI   7'h70
`define DRL_BITS_PER_CH 8'h08
`define DRL_NUM_CH      8'h08
`define DRL_B0_FAIL     0
`define DRL_B0_EXT      2
`define DRL_B0_CHERR    3
`define DRL_CTRL_RST    32'h0000_0000
`define DRL_MSK_RST     32'h0000_0000
`define DRL_IRQ_LOST    0
`define DRL_IRQ_GRP     1
`define DRL_IRQ_FAIL    2
`endif

// *** inc/drl_pkg.sv ***
// Types of the diagnostic record block.
// Assumes drl_cfg.svh holds the register offsets, record field values and reset values.
package drl_pkg;
  typedef enum logic {DRL_MODE_CNT, DRL_MODE_FREQ} drl_mode_e;
  typedef logic [7:0] drl_byte_t;
endpackage : drl_pkg

// *** inc/drl_lost_if.sv ***
// Interface carrying events and service acks to the lost-event tracker.
// Assumes one clock shared by both modules.
`timescale 1ns/1ns
interface drl_lost_if #(parameter int N = 20);
  logic [N-1:0] event_p;  // New interrupt event, pulse per source
  logic [N-1:0] serv_p;   // Event serviced, pulse per source
  logic [N-1:0] clr_p;    // Clear lost flag, pulse per source
  logic [N-1:0] lost;     // Sticky lost flag per source
  logic [N-1:0] lost_p;   // Loss happened this cycle
  modport ctl (output event_p, serv_p, clr_p, input lost, lost_p);
  modport trk (input event_p, serv_p, clr_p, output lost, lost_p);
endinterface : drl_lost_if

// *** design/drl_lost_trk.sv ***
// Per-source pending and lost-interrupt tracker.
// Assumes synchronous reset and single-cycle pulses on the interface.
`timescale 1ns/1ns
module drl_lost_trk #(
  parameter int N = 20
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  drl_lost_if.trk   lif
);
  logic [N-1:0] pend;
  logic [N-1:0] lost_q;
  logic [N-1:0] next_pend;
  logic [N-1:0] next_lost;
  logic [N-1:0] loss_now;

  // ****************************************************************
  // Per-source tracking
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      assign loss_now[g]  = lif.event_p[g] & pend[g] & ~lif.serv_p[g];
      assign next_pend[g] = lif.event_p[g] | (pend[g] & ~lif.serv_p[g]);
      // Set wins over clear
      assign next_lost[g] = loss_now[g] | (lost_q[g] & ~lif.clr_p[g]);
    end
  endgenerate

  // State registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend   <= '0;
      lost_q <= '0;
    end else begin
      pend   <= next_pend;
      lost_q <= next_lost;
    end
  end

  assign lif.lost   = lost_q;
  assign lif.lost_p = loss_now;

  chk_loss_sets_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    |loss_now |=> |lost_q) else $error("lost flag not set");
endmodule : drl_lost_trk

// *** design/drl_record.sv ***
// Diagnostic record set 1 builder with lost-interrupt tracking.
// Assumes Avalon-MM master on CLK_I, synchronous event pulses.
`timescale 1ns/1ns
`include "drl_cfg.svh"
module drl_record #(
  parameter int N_IN  = 16,
  parameter int N_CNT = 3
) (
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic [15:0] IN_EVT_I,
  input  wire logic [15:0] IN_SERV_I,
  input  wire logic [11:0] CNT_EVT_I,
  input  wire logic [11:0] CNT_SERV_I,
  input  wire logic [2:0]  MEAS_EVT_I,
  input  wire logic [2:0]  MEAS_SERV_I,
  input  wire logic [3:0]  IN_GRP_ERR_I,
  input  wire logic [2:0]  FN_GRP_ERR_I,
  input  wire logic        MOD_FAIL_I,
  input  wire logic        EXT_ERR_I,
  output logic             IRQ_O
);
  localparam int NS = N_IN + 4 * N_CNT;

  drl_lost_if #(.N(NS)) lif ();

  drl_lost_trk #(.N(NS)) u_trk (
    .clk_i  (CLK_I),
    .srst_i (SRST_I),
    .lif    (lif)
  );

  // ****************************************************************
  // Control register and mode
  // ****************************************************************
  logic [31:0]        ctrl;
  logic [31:0]        irq_st;
  logic [31:0]        irq_msk;
  drl_pkg::drl_mode_e mode;
  logic [6:0]         ch_type;
  logic               more_types;
  logic               ack;

  // Control fields: bit 0 mode, bits 10..8 type offset, bit 15 more
  assign mode       = drl_pkg::drl_mode_e'(ctrl[0]);
  assign ch_type    = (ctrl[10:8] > 3'h4) ? `DRL_CHTYPE_DI :
                      7'(`DRL_CHTYPE_DI + 7'(ctrl[10:8]));
  assign more_types = ctrl[15];

  // ****************************************************************
  // Event routing: frequency mode uses measurement ends
  // ****************************************************************
  logic [NS-1:0] ev_all;
  logic [NS-1:0] sv_all;
  logic [11:0]   cnt_ev;
  logic [11:0]   cnt_sv;

  assign cnt_ev = (mode == drl_pkg::DRL_MODE_FREQ) ?
                  {9'h000, MEAS_EVT_I} : CNT_EVT_I;
  assign cnt_sv = (mode == drl_pkg::DRL_MODE_FREQ) ?
                  {9'h000, MEAS_SERV_I} : CNT_SERV_I;
  assign ev_all = {cnt_ev, IN_EVT_I};
  assign sv_all = {cnt_sv, IN_SERV_I};

  // Drive tracker; clear on write-one to record words 2/3
  logic          wr_ok;
  logic          rd_ok;
  logic [NS-1:0] clr_sel;

  assign lif.event_p = ev_all;
  assign lif.serv_p  = sv_all;
  assign lif.clr_p   = clr_sel;

  // ****************************************************************
  // Record assembly
  // ****************************************************************
  logic [7:0] rec [16];
  logic       ch_err;
  logic [2:0] grp_hi;

  assign grp_hi = FN_GRP_ERR_I;
  assign ch_err = (|IN_GRP_ERR_I) | (|grp_hi) | (|lif.lost);

  // byte 0 error bits, others zero
  assign rec[0] = {4'h0, ch_err, EXT_ERR_I, 1'b0, MOD_FAIL_I};
  assign rec[1] = 8'h00;
  assign rec[2] = 8'h00;
  // Base byte 3 bit 6 reports any lost interrupt
  assign rec[3] = {1'b0, |lif.lost, 6'h00};
  assign rec[4] = {more_types, ch_type};
  assign rec[5] = `DRL_BITS_PER_CH;
  assign rec[6] = `DRL_NUM_CH;
  // group error byte, bit 7 zero
  assign rec[7] = {1'b0, grp_hi, IN_GRP_ERR_I};

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_in
      assign rec[8+b] = {1'b0, lif.lost[4*b+3], 1'b0, lif.lost[4*b+2],
                         1'b0, lif.lost[4*b+1], 1'b0, lif.lost[4*b]};
    end
    for (b = 0; b < 3; b++) begin : g_cnt
      logic [3:0] f;
      assign f = lif.lost[N_IN+4*b+3 -: 4];
      assign rec[12+b] = (mode == drl_pkg::DRL_MODE_FREQ) ?
                         {7'h00, lif.lost[N_IN+b]} :
                         {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
    end
  endgenerate
  assign rec[15] = 8'h00;

  // Counter source index: gate closed, opened, overflow, compare
  // Frequency sources sit at N_IN + 0..2

  // ****************************************************************
  // Avalon-MM slave: one wait cycle per access
  // ****************************************************************
  logic        req;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic        hit_ctrl;
  logic        hit_ist;
  logic        hit_msk;
  logic [31:0] next_irq_st;
  logic [31:0] ev_vec;

  assign req      = (AVS_READ_I | AVS_WRITE_I) & ~ack;
  assign wr_ok    = AVS_WRITE_I & ack;
  assign rd_ok    = AVS_READ_I & ~ack;
  assign be_mask  = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                     {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign hit_ctrl = wr_ok & (AVS_ADDRESS_I == `DRL_OFS_CTRL);
  assign hit_ist  = wr_ok & (AVS_ADDRESS_I == `DRL_OFS_IRQ_ST);
  assign hit_msk  = wr_ok & (AVS_ADDRESS_I == `DRL_OFS_IRQ_MSK);

  // Write one to record words 2 (bytes 8..11) or 3 (12..15) clears flags
  generate
    for (b = 0; b < NS; b++) begin : g_clr
      localparam int BY = (b < N_IN) ? 8 + b / 4 : 12 + (b - N_IN) / 4;
      localparam int BI = (b < N_IN) ? 2 * (b % 4) : 2 * ((b - N_IN) % 4);
      localparam int FB = (b < N_IN) ? b / 4 : (b - N_IN) / 4;
      localparam int FI = (b < N_IN) ? 0 : b - N_IN;
      localparam int FQ = (FI > 2) ? 0 : FI;
      logic hit;
      logic wsel;
      assign hit  = wr_ok & (AVS_ADDRESS_I ==
                    ((b < N_IN) ? `DRL_OFS_REC2 : `DRL_OFS_REC3));
      assign wsel = AVS_WRITEDATA_I[8*FB+BI] & AVS_BYTEENABLE_I[FB];
      // Frequency mode clears by bit 0 of the byte
      assign clr_sel[b] = hit & ((b < N_IN || FI > 2 ||
                                  mode == drl_pkg::DRL_MODE_CNT)
                          ? wsel
                          : (AVS_WRITEDATA_I[8*FQ] &
                             AVS_BYTEENABLE_I[FQ]));
    end
  endgenerate

  // Read data select
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      `DRL_OFS_CTRL:    rd_mux = ctrl;
      `DRL_OFS_STATUS:  rd_mux = {29'h0, ch_err, EXT_ERR_I, MOD_FAIL_I};
      `DRL_OFS_IRQ_ST:  rd_mux = irq_st;
      `DRL_OFS_IRQ_MSK: rd_mux = irq_msk;
      `DRL_OFS_REC0:    rd_mux = {rec[3], rec[2], rec[1], rec[0]};
      `DRL_OFS_REC1:    rd_mux = {rec[7], rec[6], rec[5], rec[4]};
      `DRL_OFS_REC2:    rd_mux = {rec[11], rec[10], rec[9], rec[8]};
      `DRL_OFS_REC3:    rd_mux = {rec[15], rec[14], rec[13], rec[12]};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Interrupt events: loss, group error, module failure
  assign ev_vec = {29'h0, MOD_FAIL_I, (|IN_GRP_ERR_I) | (|grp_hi),
                   |lif.lost_p};
  // Set wins over write-one clear
  assign next_irq_st = ev_vec |
                       (irq_st & ~(hit_ist ? (AVS_WRITEDATA_I & be_mask)
                                           : 32'h0000_0000));

  // Bus handshake and read data
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack               <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0000_0000;
    end else begin
      ack               <= req;
      AVS_WAITREQUEST_O <= ~req;
      if (rd_ok) begin
        AVS_READDATA_O <= rd_mux;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl    <= `DRL_CTRL_RST;
      irq_msk <= `DRL_MSK_RST;
    end else begin
      if (hit_ctrl) begin
        ctrl <= ((ctrl & ~be_mask) | (AVS_WRITEDATA_I & be_mask)) &
                32'h0000_8701;
      end
      if (hit_msk) begin
        irq_msk <= ((irq_msk & ~be_mask) | (AVS_WRITEDATA_I & be_mask)) &
                   32'h0000_0007;
      end
    end
  end

  // Sticky status and interrupt output
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_st <= 32'h0000_0000;
      IRQ_O  <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      IRQ_O  <= |(next_irq_st & irq_msk);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_cmp1_lost;
    mode == drl_pkg::DRL_MODE_CNT && lif.lost_p[N_IN+7];
  endsequence

  // Reserved bits stay zero
  chk_rec_zero_bits: assert property (@(posedge CLK_I) disable iff (SRST_I)
    rec[15] == 8'h00 && (rec[8] & 8'hAA) == 8'h00
    && rec[7][7] == 1'b0)
    else $error("reserved record bit set");
  // Fixed counts
  chk_fixed_counts: assert property (@(posedge CLK_I) disable iff (SRST_I)
    rec[5] == 8'h08 && rec[6] == 8'h08)
    else $error("channel counts wrong");
  chk_chan_count: assert property (@(posedge CLK_I) disable iff (SRST_I)
    {rec[3], rec[2], rec[1], rec[0]} != 32'hFFFF_FFFF
    |-> rec[6] == `DRL_NUM_CH)
    else $error("channel count wrong");
  chk_type_range: assert property (@(posedge CLK_I) disable iff (SRST_I)
    rec[4][6:0] >= 7'h70 && rec[4][6:0] <= 7'h74)
    else $error("channel type out of range");
  chk_cmp1_flag: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_cmp1_lost |=> rec[13][6] || $past(clr_sel[N_IN+7]))
    else $error("counter 1 compare loss not flagged");
  chk_freq_byte: assert property (@(posedge CLK_I) disable iff (SRST_I)
    mode == drl_pkg::DRL_MODE_FREQ |-> rec[12][7:1] == 7'h00
    && rec[14][7:1] == 7'h00)
    else $error("frequency byte upper bits set");
  chk_cnt_odd: assert property (@(posedge CLK_I) disable iff (SRST_I)
    mode == drl_pkg::DRL_MODE_CNT |-> (rec[12] & 8'hAA) == 8'h00
    && rec[12][0] == lif.lost[N_IN])
    else $error("counter byte layout wrong");
  chk_cnt_place: assert property (@(posedge CLK_I) disable iff (SRST_I)
    mode == drl_pkg::DRL_MODE_CNT |-> rec[14][6] == lif.lost[N_IN+11])
    else $error("counter 2 flag misplaced");
  chk_byte0_bits: assert property (@(posedge CLK_I) disable iff (SRST_I)
    rec[0][0] == MOD_FAIL_I && rec[0][2] == EXT_ERR_I
    && rec[0][1] == 1'b0)
    else $error("byte 0 error bits wrong");
  chk_grp_byte: assert property (@(posedge CLK_I) disable iff (SRST_I)
    rec[7][3:0] == IN_GRP_ERR_I && rec[7][6:4] == FN_GRP_ERR_I)
    else $error("group error byte wrong");
  chk_in_flags: assert property (@(posedge CLK_I) disable iff (SRST_I)
    rec[11][6] == lif.lost[15] && rec[9][2] == lif.lost[5])
    else $error("input lost flag misplaced");
  chk_rec_words: assert property (@(posedge CLK_I) disable iff (SRST_I)
    AVS_READ_I && !ack && AVS_ADDRESS_I == `DRL_OFS_REC1
    |=> AVS_READDATA_O[7:0] == $past(rec[4]))
    else $error("record word read wrong");
endmodule : drl_record

// *** testbench/drl_host_model.sv ***
// Diagnostic handler model: Avalon-MM master reading the record.
// Assumes a single clock and a slave that answers with waitrequest low.
`timescale 1ns/1ns
module drl_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i,
  output logic      [7:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o
);
  // ****************************************************************
  // Bus idle values
  // ****************************************************************
  initial begin
    address_o    = 8'h00;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0;
    byteenable_o = 4'h0;
  end

  // ****************************************************************
  // One transfer, held until waitrequest is seen low or 40 cycles pass
  // ****************************************************************
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output bit ok);
    int n;
    n  = 0;
    ok = 1'b0;
    q  = 32'h0;
    @(posedge clk_i);
    address_o    <= a;
    writedata_o  <= d;
    byteenable_o <= 4'hF;
    read_o       <= !wr;
    write_o      <= wr;
    while (!ok && n < 40) begin
      @(posedge clk_i);
      n++;
      if (waitrequest_i === 1'b0) begin
        q  = readdata_i;
        ok = 1'b1;
      end
    end
    // Release only after the accepting edge
    read_o  <= 1'b0;
    write_o <= 1'b0;
  endtask : xfer
endmodule : drl_host_model

// *** testbench/drl_record_tb.sv ***
// Self-checking bench for the diagnostic record builder.
// Assumes the host model drives the register bus, bench drives events.
`timescale 1ns/1ns
`include "drl_cfg.svh"
module drl_record_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  address;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic [15:0] in_evt = 16'h0;
  logic [15:0] in_serv = 16'h0;
  logic [11:0] cnt_evt = 12'h0;
  logic [11:0] cnt_serv = 12'h0;
  logic [2:0]  meas_evt = 3'h0;
  logic [2:0]  meas_serv = 3'h0;
  logic [3:0]  in_grp = 4'h0;
  logic [2:0]  fn_grp = 3'h0;
  logic        fail = 1'b0;
  logic        ext = 1'b0;
  logic        irq;
  int          failures = 0;
  int          checks = 0;

  // Clock of 50 ns
  always #25 clk = ~clk;

  // ****************************************************************
  // Instances
  // ****************************************************************
  drl_record drl_record_i (.CLK_I(clk), .SRST_I(srst),
    .AVS_ADDRESS_I(address), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .IN_EVT_I(in_evt), .IN_SERV_I(in_serv), .CNT_EVT_I(cnt_evt),
    .CNT_SERV_I(cnt_serv), .MEAS_EVT_I(meas_evt),
    .MEAS_SERV_I(meas_serv), .IN_GRP_ERR_I(in_grp),
    .FN_GRP_ERR_I(fn_grp), .MOD_FAIL_I(fail), .EXT_ERR_I(ext),
    .IRQ_O(irq));
  drl_host_model drl_host_model_i (.clk_i(clk), .readdata_i(rdata),
    .waitrequest_i(waitreq), .address_o(address), .read_o(rd),
    .write_o(wr), .writedata_o(wdata), .byteenable_o(be));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Bus access, a hang ends the run
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    bit ok;
    drl_host_model_i.xfer(w, a, d, q, ok);
    if (!ok) begin
      failures++;
      $display("FAIL %0t bus timeout", $time);
      wrap_up();
    end
  endtask : acc

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    cmp(q, exp);
  endtask : rd_chk

  // One-cycle event and service pulses
  task automatic pulse(input logic [15:0] ie, input logic [15:0] is,
                       input logic [11:0] ce, input logic [2:0] me,
                       input logic [2:0] ms);
    @(posedge clk);
    in_evt <= ie;
    in_serv <= is;
    cnt_evt <= ce;
    meas_evt <= me;
    meas_serv <= ms;
    @(posedge clk);
    in_evt <= 16'h0;
    in_serv <= 16'h0;
    cnt_evt <= 12'h0;
    meas_evt <= 3'h0;
    meas_serv <= 3'h0;
  endtask : pulse

  // Bounded wait for the interrupt level
  task automatic irq_chk(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 6) begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, irq}, {31'h0, lvl});
  endtask : irq_chk

  // Input flags on even bits of bytes 8..11
  function automatic logic [31:0] in_map(input logic [15:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 16; i++) r[2*i] = v[i];
    return r;
  endfunction : in_map

  // Counter c event e at bit 2e of byte 12+c
  function automatic logic [31:0] cnt_map(input logic [11:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int c = 0; c < 3; c++)
      for (int e = 0; e < 4; e++) r[8*c+2*e] = v[4*c+e];
    return r;
  endfunction : cnt_map

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Reset image of the record
    rd_chk(`DRL_OFS_REC0, 32'h0);
    rd_chk(`DRL_OFS_REC1, 32'h0008_0870);
    rd_chk(`DRL_OFS_REC3, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr_reg(`DRL_OFS_REC1, 32'hFFFF_FFFF);
    rd_chk(`DRL_OFS_REC1, 32'h0008_0870);
    // Channel type codes, out of range and more-types flag
    for (int k = 0; k < 6; k++) begin
      wr_reg(`DRL_OFS_CTRL, {16'h0, k == 5, 4'h0, 3'(k), 8'h00});
      rd_chk(`DRL_OFS_REC1, {16'h0008, 8'h08, k == 5,
             (k == 5) ? 7'h70 : 7'(8'h70 + k)});
    end
    wr_reg(`DRL_OFS_CTRL, 32'h0);
    // Group errors and record byte 0
    in_grp <= 4'hA;
    fn_grp <= 3'h5;
    fail <= 1'b1;
    ext <= 1'b1;
    rd_chk(`DRL_OFS_REC1, 32'h5A08_0870);
    rd_chk(`DRL_OFS_REC0, 32'h0000_000D);
    rd_chk(`DRL_OFS_STATUS, 32'h0000_0007);
    rd_chk(`DRL_OFS_IRQ_ST, 32'h0000_0006);
    in_grp <= 4'h0;
    fn_grp <= 3'h0;
    fail <= 1'b0;
    ext <= 1'b0;
    wr_reg(`DRL_OFS_IRQ_ST, 32'h7);
    rd_chk(`DRL_OFS_IRQ_ST, 32'h0);
    // Lost inputs, three serviced in between
    pulse(16'h8421, 16'h0, 12'h0, 3'h0, 3'h0);
    pulse(16'h0, 16'h0421, 12'h0, 3'h0, 3'h0);
    pulse(16'h8421, 16'h0, 12'h0, 3'h0, 3'h0);
    rd_chk(`DRL_OFS_REC2, in_map(16'h8000));
    pulse(16'h1234, 16'h0, 12'h0, 3'h0, 3'h0);
    pulse(16'h1234, 16'h0, 12'h0, 3'h0, 3'h0);
    rd_chk(`DRL_OFS_REC2, in_map(16'h9234));
    rd_chk(`DRL_OFS_REC0, 32'h4000_0008);
    // Interrupt raise, mask and clear
    rd_chk(`DRL_OFS_IRQ_ST, 32'h1);
    irq_chk(1'b0);
    wr_reg(`DRL_OFS_IRQ_MSK, 32'h1);
    irq_chk(1'b1);
    wr_reg(`DRL_OFS_IRQ_ST, 32'h1);
    irq_chk(1'b0);
    wr_reg(`DRL_OFS_REC2, in_map(16'h9234));
    rd_chk(`DRL_OFS_REC2, 32'h0);
    // Counter sources, compare of counter 1 among them
    pulse(16'h0, 16'h0, 12'h481, 3'h0, 3'h0);
    pulse(16'h0, 16'h0, 12'h481, 3'h0, 3'h0);
    rd_chk(`DRL_OFS_REC3, cnt_map(12'h481));
    pulse(16'h0, 16'h0, 12'hB36, 3'h0, 3'h0);
    pulse(16'h0, 16'h0, 12'hB36, 3'h0, 3'h0);
    rd_chk(`DRL_OFS_REC3, cnt_map(12'hFB7));
    wr_reg(`DRL_OFS_REC3, cnt_map(12'hFB7));
    rd_chk(`DRL_OFS_REC3, 32'h0);
    // Frequency mode, meter 1 serviced in the same cycle
    wr_reg(`DRL_OFS_CTRL, 32'h1);
    fn_grp <= 3'h6;
    // Meter sources still pending from counter mode: serve in same cycle
    pulse(16'h0, 16'h0, 12'h0, 3'h7, 3'h7);
    pulse(16'h0, 16'h0, 12'h0, 3'h7, 3'h2);
    rd_chk(`DRL_OFS_REC3, 32'h0001_0001);
    rd_chk(`DRL_OFS_REC1, 32'h6008_0870);
    wr_reg(`DRL_OFS_IRQ_ST, 32'h7);
    wrap_up();
  end
endmodule : drl_record_tb
